// ### gorb_bank_assertions.sv
// concurrent checks on the ports of the gyro register bank
`timescale 1ns/1ps
`default_nettype none
module gorb_bank_assertions (
	// clock and reset
	input wire logic                    core_clk,
	input wire logic                    sys_rst,
	// serial port
	input wire gorb_pkg::gorb_spi_in_t  spiIn,
	input wire gorb_pkg::gorb_spi_out_t spiOut,
	// sensing side
	input wire gorb_pkg::gorb_sense_t   sense,
	input wire gorb_pkg::gorb_analog_t  analog,
	input wire logic                    readyPin
);
	import gorb_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence sr_pulse_s;
		analog.softReset ##1 !analog.softReset;
	endsequence
	sequence cleared_s;
		analog.powerMode == PWR_DOWN && !analog.hpInsert && analog.lowpassHz == 11'h122;
	endsequence
	boot_pulse_a: assert property (analog.bootPulse |=> !analog.bootPulse)
		else $error("boot pulse longer than one cycle");
	hp_clear_a: assert property (analog.hpClear |=> !analog.hpClear)
		else $error("filter clear pulse longer than one cycle");
	soft_clear_a: assert property (sr_pulse_s |-> ##[0:1] cleared_s)
		else $error("soft reset left control state");
	ctl_hold_a: assert property ($changed({analog.powerMode, analog.hpInsert,
		analog.lowpassHz, analog.selftestOn, analog.selftestPolarity}) |-> !$past(spiIn.csN)
		|| $past(analog.softReset) || $past(analog.softReset, 2))
		else $error("control output moved without a write");
	single_drive_a: assert property (!(spiOut.sdoOe && spiOut.sdiOe))
		else $error("both data outputs enabled");
	port_release_a: assert property (spiIn.csN |=> !spiOut.sdoOe && !spiOut.sdiOe)
		else $error("data output driven while deselected");
	power_code_a: assert property (analog.powerMode inside {PWR_DOWN, PWR_SLEEP, PWR_NORMAL})
		else $error("power mode out of range");
	lowpass_set_a: assert property (analog.lowpassHz inside
		{11'h122, 11'hd2, 11'ha0, 11'h1c2, 11'h47e}) else $error("bandwidth out of table");
	data_stable_a: assert property (spiOut.sdoOe && $past(spiOut.sdoOe) && spiIn.clk
		&& $past(spiIn.clk) && $past(spiIn.clk, 2) |-> $stable(spiOut.sdoOut))
		else $error("read bit moved without a clock fall");
endmodule : gorb_bank_assertions
bind gorb_register_bank gorb_bank_assertions chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.spiIn(spiIn), .spiOut(spiOut), .sense(sense), .analog(analog), .readyPin(readyPin));
`default_nettype wire

// ### gorb_pkg.sv
// constants, enumerations and carriers of the gyro register bank
`default_nettype none
package gorb_pkg;
	// register offsets
	localparam logic [5:0] ADDR_IDENTITY = 6'h00;
	localparam logic [5:0] ADDR_TEMP_LO  = 6'h01;
	localparam logic [5:0] ADDR_TEMP_HI  = 6'h02;
	localparam logic [5:0] ADDR_X_LO     = 6'h03;
	localparam logic [5:0] ADDR_X_HI     = 6'h04;
	localparam logic [5:0] ADDR_Y_LO     = 6'h05;
	localparam logic [5:0] ADDR_Y_HI     = 6'h06;
	localparam logic [5:0] ADDR_STATUS   = 6'h0a;
	localparam logic [5:0] ADDR_CTL1     = 6'h0b;
	localparam logic [5:0] ADDR_CTL2     = 6'h0c;
	localparam logic [5:0] ADDR_CTL3     = 6'h0d;
	// identity value, arbitrary
	localparam logic [7:0] IDENTITY_VALUE = 8'h5c;
	// control one fields
	localparam int C1_BOOT   = 7;
	localparam int C1_PULSE  = 6;
	localparam int C1_ORDER  = 5;
	localparam int C1_WIRE   = 4;
	localparam int C1_UPDATE = 3;
	localparam int C1_SWAP   = 2;
	// control two fields
	localparam int C2_XSIGN = 7;
	localparam int C2_YSIGN = 6;
	localparam int C2_LPLO  = 4;
	localparam int C2_HPCLR = 2;
	localparam int C2_SWRST = 1;
	localparam int C2_HPON  = 0;
	// control three fields
	localparam int C3_STPOL = 4;
	localparam int C3_STON  = 3;
	localparam int C3_POL   = 1;
	localparam int C3_LPTOP = 0;
	// reset values and storable bits
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] C2_KEEP   = 8'hf1;
	localparam logic [7:0] C3_KEEP   = 8'h1b;
	// high-pass averaging shift
	localparam int HP_SHIFT = 6;
	// low-pass bandwidths in Hz
	localparam logic [10:0] LP_HZ_0 = 11'd290;
	localparam logic [10:0] LP_HZ_1 = 11'd210;
	localparam logic [10:0] LP_HZ_2 = 11'd160;
	localparam logic [10:0] LP_HZ_3 = 11'd450;
	localparam logic [10:0] LP_HZ_W = 11'd1150;

	typedef enum logic [1:0] {PWR_DOWN, PWR_SLEEP, PWR_NORMAL} gorb_power_t;
	typedef enum logic [1:0] {SPI_IDLE, SPI_HEADER, SPI_DATA} gorb_phase_t;

	typedef struct packed {
		logic csN;
		logic clk;
		logic sdiIn;
	} gorb_spi_in_t;

	typedef struct packed {
		logic sdoOut;
		logic sdoOe;
		logic sdiOut;
		logic sdiOe;
	} gorb_spi_out_t;

	typedef struct packed {
		logic        sampleValid;
		logic [15:0] rateX;
		logic [15:0] rateY;
		logic        tempValid;
		logic [11:0] temp;
	} gorb_sense_t;

	typedef struct packed {
		gorb_power_t powerMode;
		logic        bootPulse;
		logic        hpClear;
		logic        hpInsert;
		logic        softReset;
		logic [10:0] lowpassHz;
		logic        selftestOn;
		logic        selftestPolarity;
	} gorb_analog_t;
endpackage : gorb_pkg
`default_nettype wire

// ### gorb_register_bank.sv
// register bank of the two-axis rate sensor, reached over its serial port
`timescale 1ns/1ps
`default_nettype none
module gorb_register_bank #(
	parameter logic [7:0] IDENTITY_P = gorb_pkg::IDENTITY_VALUE
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	// serial register port
	input  wire gorb_pkg::gorb_spi_in_t  spiIn,
	output var  gorb_pkg::gorb_spi_out_t spiOut,
	// sensing chain
	input  wire gorb_pkg::gorb_sense_t   sense,
	output var  gorb_pkg::gorb_analog_t  analog,
	// data-ready pin
	output var  logic                    readyPin
);
	import gorb_pkg::*;

	typedef struct packed {
		// serial port state
		gorb_phase_t      phase;
		logic             sclPrev;
		logic [2:0]       bitCnt;
		logic             isRead;
		logic             autoInc;
		logic [5:0]       addr;
		logic [7:0]       rxShift;
		logic [7:0]       txShift;
		logic             sdoBit;
		// control registers
		logic [7:0]       ctl1;
		logic [7:0]       ctl2;
		logic [7:0]       ctl3;
		// sample path
		logic [1:0][15:0] shadow;
		logic [1:0][15:0] visible;
		logic [1:0][15:0] hpAvg;
		logic [11:0]      temp;
		// flags and read tracking
		logic [1:0]       newFlag;
		logic [1:0]       ovrFlag;
		logic             globalOvr;
		logic [1:0][1:0]  readMask;
		// one-cycle strobes
		logic             bootPulse;
		logic             hpClrPulse;
		logic             swRstPulse;
		logic             readyPulse;
	} gorb_state_t;

	gorb_state_t state_r;
	gorb_state_t state_nxt;

	// byte of a 16-bit output at the low or high address of its pair
	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic atHigh,
			input logic msbFirst);
		return (atHigh ^ msbFirst) ? w[15:8] : w[7:0];
	endfunction : pick_byte

	// power mode decode
	function automatic gorb_power_t power_of(input logic [1:0] f);
		case (f)
			2'b10:   return PWR_SLEEP;
			2'b11:   return PWR_NORMAL;
			default: return PWR_DOWN;
		endcase
	endfunction : power_of

	// bandwidth decode
	function automatic logic [10:0] lowpass_hz(input logic [2:0] sel);
		case (sel)
			3'b000:  return LP_HZ_0;
			3'b001:  return LP_HZ_1;
			3'b010:  return LP_HZ_2;
			3'b011:  return LP_HZ_3;
			default: return LP_HZ_W;
		endcase
	endfunction : lowpass_hz

	// register read mux
	function automatic logic [7:0] read_reg(input gorb_state_t s, input logic [5:0] a);
		logic order;
		order = s.ctl1[C1_ORDER];
		case (a)
			ADDR_IDENTITY: return IDENTITY_P;
			ADDR_TEMP_LO:  return pick_byte({s.temp, 4'h0}, 1'b0, order);
			ADDR_TEMP_HI:  return pick_byte({s.temp, 4'h0}, 1'b1, order);
			ADDR_X_LO:     return pick_byte(s.visible[1], 1'b0, order);
			ADDR_X_HI:     return pick_byte(s.visible[1], 1'b1, order);
			ADDR_Y_LO:     return pick_byte(s.visible[0], 1'b0, order);
			ADDR_Y_HI:     return pick_byte(s.visible[0], 1'b1, order);
			ADDR_STATUS:   return {s.globalOvr, s.ovrFlag, 1'b0, &s.newFlag,
				s.newFlag, 1'b0};
			ADDR_CTL1:     return s.ctl1;
			ADDR_CTL2:     return s.ctl2;
			ADDR_CTL3:     return s.ctl3;
			default:       return 8'h00;
		endcase
	endfunction : read_reg

	always_comb begin
		logic             selected;
		logic             sclRise;
		logic             sclFall;
		logic [7:0]       rxNext;
		logic [7:0]       rdData;
		logic             rdAccess;
		logic             wrAccess;
		logic [5:0]       accAddr;
		logic [1:0][15:0] mapped;
		logic [15:0]      diff;
		logic [15:0]      path;
		logic             slotX;
		logic [1:0]       slotHit;
		selected = 1'b0;
		sclRise  = 1'b0;
		sclFall  = 1'b0;
		rxNext   = 8'h00;
		rdData   = 8'h00;
		rdAccess = 1'b0;
		wrAccess = 1'b0;
		accAddr  = state_r.addr;
		mapped   = '0;
		diff     = 16'h0000;
		path     = 16'h0000;
		slotX    = 1'b0;
		slotHit  = 2'b00;

		state_nxt            = state_r;
		state_nxt.bootPulse  = 1'b0;
		state_nxt.hpClrPulse = 1'b0;
		state_nxt.swRstPulse = 1'b0;
		state_nxt.readyPulse = 1'b0;

		// serial port: capture on rising clock, drive on falling clock
		selected          = !spiIn.csN;
		sclRise           = selected && spiIn.clk && !state_r.sclPrev;
		sclFall           = selected && !spiIn.clk && state_r.sclPrev;
		state_nxt.sclPrev = spiIn.clk;
		rxNext            = {state_r.rxShift[6:0], spiIn.sdiIn};
		if (!selected) begin
			state_nxt.phase  = SPI_IDLE;
			state_nxt.bitCnt = 3'd0;
			state_nxt.sdoBit = 1'b0;
		end else begin
			case (state_r.phase)
				SPI_IDLE: begin
					state_nxt.phase  = SPI_HEADER;
					state_nxt.bitCnt = 3'd0;
				end
				SPI_HEADER: begin
					if (sclRise) begin
						state_nxt.rxShift = rxNext;
						state_nxt.bitCnt  = 3'(state_r.bitCnt + 3'd1);
						if (state_r.bitCnt == 3'd7) begin
							state_nxt.isRead  = rxNext[7];
							state_nxt.autoInc = rxNext[6];
							state_nxt.addr    = rxNext[5:0];
							state_nxt.phase   = SPI_DATA;
						end
					end
				end
				SPI_DATA: begin
					if (sclFall && state_r.isRead) begin
						if (state_r.bitCnt == 3'd0) begin
							rdAccess          = 1'b1;
							rdData            = read_reg(state_r, state_r.addr);
							state_nxt.sdoBit  = rdData[7];
							state_nxt.txShift = {rdData[6:0], 1'b0};
							if (state_r.autoInc) begin
								state_nxt.addr = 6'(state_r.addr + 6'd1);
							end
						end else begin
							state_nxt.sdoBit  = state_r.txShift[7];
							state_nxt.txShift = {state_r.txShift[6:0], 1'b0};
						end
					end
					if (sclRise) begin
						state_nxt.rxShift = rxNext;
						state_nxt.bitCnt  = 3'(state_r.bitCnt + 3'd1);
						if (state_r.bitCnt == 3'd7 && !state_r.isRead) begin
							wrAccess = 1'b1;
							if (state_r.autoInc) begin
								state_nxt.addr = 6'(state_r.addr + 6'd1);
							end
						end
					end
				end
				default: state_nxt.phase = SPI_IDLE;
			endcase
		end

		// reboot served once the oscillator runs
		if (state_r.ctl1[C1_BOOT] && power_of(state_r.ctl1[1:0]) != PWR_DOWN) begin
			state_nxt.bootPulse     = 1'b1;
			state_nxt.ctl1[C1_BOOT] = 1'b0;
		end

		// register writes
		if (wrAccess) begin
			case (accAddr)
				ADDR_CTL1: state_nxt.ctl1 = rxNext;
				ADDR_CTL2: begin
					state_nxt.ctl2       = rxNext & C2_KEEP;
					state_nxt.hpClrPulse = rxNext[C2_HPCLR];
					state_nxt.swRstPulse = rxNext[C2_SWRST];
				end
				ADDR_CTL3: state_nxt.ctl3 = rxNext & C3_KEEP;
				default: state_nxt.ctl1 = state_nxt.ctl1;
			endcase
		end

		// read side effects, before new events so that a set wins
		if (rdAccess) begin
			if (accAddr == ADDR_STATUS) begin
				state_nxt.ovrFlag   = 2'b00;
				state_nxt.globalOvr = 1'b0;
			end
			if (accAddr >= ADDR_X_LO && accAddr <= ADDR_Y_HI) begin
				slotX   = (accAddr <= ADDR_X_HI);
				slotHit = (accAddr == ADDR_X_HI || accAddr == ADDR_Y_HI) ? 2'b10 : 2'b01;
				if ((state_r.readMask[slotX] | slotHit) == 2'b11) begin
					state_nxt.readMask[slotX] = 2'b00;
					state_nxt.newFlag[slotX]  = 1'b0;
				end else begin
					state_nxt.readMask[slotX] = state_r.readMask[slotX] | slotHit;
				end
			end
		end

		// sample path: swap, high-pass, sign
		mapped[1] = state_r.ctl1[C1_SWAP] ? sense.rateY : sense.rateX;
		mapped[0] = state_r.ctl1[C1_SWAP] ? sense.rateX : sense.rateY;
		for (int i = 0; i < 2; i++) begin
			diff = 16'(mapped[i] - state_r.hpAvg[i]);
			path = state_r.ctl2[C2_HPON] ? diff : mapped[i];
			if (state_r.ctl2[C2_XSIGN - 1 + i]) begin
				path = 16'(-path);
			end
			if (state_r.hpClrPulse || !state_r.ctl2[C2_HPON]) begin
				state_nxt.hpAvg[i] = 16'h0000;
			end else if (sense.sampleValid) begin
				state_nxt.hpAvg[i] = 16'(state_r.hpAvg[i] + 16'($signed(diff) >>> HP_SHIFT));
			end
			if (sense.sampleValid) begin
				state_nxt.shadow[i]  = path;
				state_nxt.newFlag[i] = 1'b1;
				if (state_r.newFlag[i]) begin
					state_nxt.ovrFlag[i] = 1'b1;
				end
			end
			if (state_r.ctl1[C1_UPDATE] || state_nxt.readMask[i] == 2'b00) begin
				state_nxt.visible[i] = state_nxt.shadow[i];
			end
		end
		if (sense.sampleValid) begin
			state_nxt.readyPulse = 1'b1;
			if (&state_r.newFlag) begin
				state_nxt.globalOvr = 1'b1;
			end
		end

		// temperature capture
		if (sense.tempValid) begin
			state_nxt.temp = sense.temp;
		end

		// soft reset of configuration and flags
		if (state_r.swRstPulse) begin
			state_nxt.ctl1      = CTL_RESET;
			state_nxt.ctl2      = CTL_RESET;
			state_nxt.ctl3      = CTL_RESET;
			state_nxt.newFlag   = 2'b00;
			state_nxt.ovrFlag   = 2'b00;
			state_nxt.globalOvr = 1'b0;
			state_nxt.readMask  = '0;
			state_nxt.hpAvg     = '0;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// pins and sensing-chain controls
	always_comb begin
		logic driving;
		logic readyLevel;
		driving    = !spiIn.csN && state_r.phase == SPI_DATA && state_r.isRead;
		// data-ready level and pin
		readyLevel = state_r.ctl1[C1_PULSE] ? state_r.readyPulse : &state_r.newFlag;
		readyPin   = readyLevel ^ state_r.ctl3[C3_POL];

		// data line drive
		spiOut.sdoOut = state_r.sdoBit;
		spiOut.sdoOe  = driving && !state_r.ctl1[C1_WIRE];
		spiOut.sdiOut = state_r.sdoBit;
		spiOut.sdiOe  = driving && state_r.ctl1[C1_WIRE];

		// sensing-chain controls
		analog.powerMode        = power_of(state_r.ctl1[1:0]);
		analog.bootPulse        = state_r.bootPulse;
		analog.hpClear          = state_r.hpClrPulse;
		analog.hpInsert         = state_r.ctl2[C2_HPON];
		analog.softReset        = state_r.swRstPulse;
		analog.lowpassHz        = lowpass_hz({state_r.ctl3[C3_LPTOP],
			state_r.ctl2[C2_LPLO +: 2]});
		analog.selftestOn       = state_r.ctl3[C3_STON];
		analog.selftestPolarity = state_r.ctl3[C3_STPOL];
	end
endmodule : gorb_register_bank
`default_nettype wire

// ### gorb_register_bank_tb.sv
// self-checking bench of the gyro register bank
`timescale 1ns/1ps
`default_nettype none
module gorb_register_bank_tb;
	import gorb_pkg::*;
	logic          core_clk  = 1'b0;
	logic          sys_rst   = 1'b1;
	logic          wire3     = 1'b0;
	gorb_sense_t   sense     = '0;
	gorb_spi_in_t  spiIn;
	gorb_spi_out_t spiOut;
	gorb_analog_t  analog;
	logic          readyPin;
	int            error_cnt = 0;
	int            compares  = 0;
	// address, written value, value read back
	logic [21:0]   rows [6]  = '{{ADDR_CTL1, 8'h4e, 8'h4e}, {ADDR_CTL2, 8'hf9, 8'hf1},
		{ADDR_CTL3, 8'hff, 8'h1b}, {6'h07, 8'h55, 8'h00}, {ADDR_IDENTITY, 8'h00,
		IDENTITY_VALUE}, {ADDR_X_LO, 8'h77, 8'h00}};
	logic [10:0]   lpHz [8]  = '{11'h122, 11'hd2, 11'ha0, 11'h1c2, 11'h47e, 11'h47e,
		11'h47e, 11'h47e};
	gorb_power_t   pwrExp [4] = '{PWR_DOWN, PWR_DOWN, PWR_SLEEP, PWR_NORMAL};
	gorb_register_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .spiIn(spiIn),
		.spiOut(spiOut), .sense(sense), .analog(analog), .readyPin(readyPin));
	gorb_spi_host host (.core_clk(core_clk), .wire3(wire3), .spiOut(spiOut), .spiIn(spiIn));
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tk
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.xfer(1'b1, a, 8'h00, q);
		chk($sformatf("reg %h", a), {8'h00, q}, {8'h00, e});
	endtask : rd
	task automatic rdp(input logic [5:0] a, input logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 6'h01, v[15:8]);
	endtask : rdp
	task automatic smp(input logic [15:0] x, input logic [15:0] y);
		sense.rateX = x;
		sense.rateY = y;
		sense.sampleValid = 1'b1;
		tk(1);
		sense.sampleValid = 1'b0;
		tk(1);
	endtask : smp
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		tk(40000);
		error_cnt++;
		give_verdict();
	end
	initial begin
		tk(12);
		sys_rst = 1'b0;
		tk(1);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i][21:16], rows[i][15:8]);
			rd(rows[i][21:16], rows[i][7:0]);
		end
		done("rows");
		sys_rst = 1'b1;
		tk(2);
		sys_rst = 1'b0;
		tk(1);
		for (int i = 0; i < 4; i++) rd(ADDR_STATUS + 6'(i), 8'h00);
		chk("lpf", 16'(analog.lowpassHz), 16'h0122);
		done("reset");
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_CTL1, 8'(p));
			chk("pwr", 16'(analog.powerMode), 16'(pwrExp[p]));
		end
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_CTL2, {2'h0, 2'(k), 4'h0});
			wr(ADDR_CTL3, {7'h00, k[2]});
			chk("lpf", 16'(analog.lowpassHz), 16'(lpHz[k]));
		end
		done("modes");
		smp(16'h1234, 16'hfffe);
		rd(ADDR_STATUS, 8'h0e);
		rdp(ADDR_X_LO, 16'h1234);
		rdp(ADDR_Y_LO, 16'hfffe);
		rd(ADDR_STATUS, 8'h00);
		smp(16'h0001, 16'h0002);
		smp(16'h0001, 16'h0002);
		rd(ADDR_STATUS, 8'hee);
		rd(ADDR_STATUS, 8'h0e);
		rdp(ADDR_X_LO, 16'h0001);
		rdp(ADDR_Y_LO, 16'h0002);
		sense.temp = 12'habc;
		sense.tempValid = 1'b1;
		tk(1);
		sense.tempValid = 1'b0;
		tk(1);
		rdp(ADDR_TEMP_LO, 16'habc0);
		done("samples");
		smp(16'h1111, 16'h0000);
		rd(ADDR_X_LO, 8'h11);
		smp(16'h2233, 16'h0000);
		rd(ADDR_X_HI, 8'h11);
		rdp(ADDR_X_LO, 16'h2233);
		rdp(ADDR_Y_LO, 16'h0000);
		wr(ADDR_CTL1, 8'h23);
		rdp(ADDR_X_LO, 16'h3322);
		wr(ADDR_CTL1, 8'h07);
		wr(ADDR_CTL2, 8'h80);
		smp(16'h1234, 16'h0002);
		rdp(ADDR_X_LO, 16'hfffe);
		rdp(ADDR_Y_LO, 16'h1234);
		done("data path");
		wr(ADDR_CTL2, 8'h05);
		chk("hp", 16'(analog.hpInsert), 16'h0001);
		wr(ADDR_CTL3, 8'h1a);
		chk("st", 16'({analog.selftestOn, analog.selftestPolarity}), 16'h0003);
		chk("rdy", 16'(readyPin), 16'h0001);
		smp(16'h0005, 16'h0006);
		chk("rdy", 16'(readyPin), 16'h0000);
		wr(ADDR_CTL2, 8'h02);
		tk(3);
		rd(ADDR_CTL3, 8'h00);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CTL1, 8'h80);
		rd(ADDR_CTL1, 8'h80);
		wr(ADDR_CTL1, 8'h82);
		tk(4);
		rd(ADDR_CTL1, 8'h02);
		wr(ADDR_CTL1, 8'h42);
		sense.sampleValid = 1'b1;
		tk(1);
		chk("rdy", 16'(readyPin), 16'h0001);
		sense.sampleValid = 1'b0;
		tk(1);
		chk("rdy", 16'(readyPin), 16'h0000);
		wr(ADDR_CTL1, 8'h10);
		wire3 = 1'b1;
		rd(ADDR_CTL1, 8'h10);
		wr(ADDR_CTL1, 8'h00);
		wire3 = 1'b0;
		rd(ADDR_CTL1, 8'h00);
		done("control");
		give_verdict();
	end
endmodule : gorb_register_bank_tb
`default_nettype wire

// ### gorb_spi_host.sv
// serial host model that runs single-byte register frames
`timescale 1ns/1ps
`default_nettype none
module gorb_spi_host (
	// clock and mode
	input  wire logic                    core_clk,
	input  wire logic                    wire3,
	// serial port
	input  wire gorb_pkg::gorb_spi_out_t spiOut,
	output var  gorb_pkg::gorb_spi_in_t  spiIn
);
	import gorb_pkg::*;
	logic csN = 1'b1;
	logic scl = 1'b1;
	logic hb  = 1'b0;
	logic rel = 1'b0;
	// a released shared line shows the inverse of its last level
	always_comb begin
		spiIn = {csN, scl, spiOut.sdiOe ? spiOut.sdiOut : (rel ? ~hb : hb)};
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// clock idles high, each level stands three cycles
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd,
			output logic [7:0] q);
		logic [15:0] f;
		f = {rd, 1'b0, a, wd};
		q = 8'h00;
		csN = 1'b0;
		cyc(3);
		for (int i = 15; i >= 0; i--) begin
			scl = 1'b0;
			hb = f[i];
			rel = rd && wire3 && i < 8;
			cyc(3);
			if (i < 8) q[i] = wire3 ? spiIn.sdiIn : spiOut.sdoOut;
			scl = 1'b1;
			cyc(3);
		end
		csN = 1'b1;
		rel = 1'b0;
		cyc(3);
	endtask : xfer
endmodule : gorb_spi_host
`default_nettype wire
